/* inc/spsp_defs.svh */
// constants for the stop-position serial pulse link
// assumes a 100 MHz control clock
`ifndef SPSP_DEFS_SVH
`define SPSP_DEFS_SVH
// ------------------------------------------------
// timing
// ------------------------------------------------
`define SPSP_CLK_HZ      100000000
`define SPSP_IDLE_MS     100
`define SPSP_IDLE_CYC    (`SPSP_IDLE_MS * (`SPSP_CLK_HZ / 1000))
`define SPSP_TICK_DIV    8'h32
// ------------------------------------------------
// configuration codes
// ------------------------------------------------
`define SPSP_SRC_TRAIN   8'h0c
`define SPSP_CM_PG_A     8'h03
`define SPSP_CM_PG_B     8'h04
`define SPSP_CM_NOPOS_A  8'h06
`define SPSP_CM_NOPOS_B  8'h0f
`define SPSP_FMT_SIGN    2'h0
`define SPSP_FMT_FWREV   2'h1
`define SPSP_FMT_QUAD    2'h2
// ------------------------------------------------
// register map, byte addresses
// ------------------------------------------------
`define SPSP_A_CFG       8'h00
`define SPSP_A_STOP_LO   8'h04
`define SPSP_A_STOP_HI   8'h08
`define SPSP_A_STATUS    8'h0c
`define SPSP_A_TRAIN     8'h10
`define SPSP_A_FBK       8'h14
// config fields
`define SPSP_CFG_SRC     7:0
`define SPSP_CFG_CM      15:8
`define SPSP_CFG_FMT     17:16
`define SPSP_CFG_SRA     18
`define SPSP_CFG_SPEN    19
`define SPSP_CFG_RST     32'h0000_0000
`endif

/* inc/spsp_pkg.sv */
// types shared by both ends of the serial pulse link
// assumes spsp_defs.svh is visible to the users
package spsp_pkg;
  // ------------------------------------------------
  // terminal group functions
  // ------------------------------------------------
  typedef enum logic [2:0] {
    FN_MONITOR  = 3'h0,
    FN_SERIAL   = 3'h1,
    FN_POSFBK   = 3'h2,
    FN_SPEEDFBK = 3'h3,
    FN_TRAIN    = 3'h4,
    FN_SPDPOS   = 3'h5
  } spsp_func_t;
  // ------------------------------------------------
  // host sequencer states
  // ------------------------------------------------
  typedef enum logic [4:0] {
    H_OFF      = 5'h01,
    H_ON_WAIT  = 5'h02,
    H_READY    = 5'h04,
    H_SEND     = 5'h08,
    H_POST_OFF = 5'h10
  } spsp_hstate_t;
endpackage : spsp_pkg

/* inc/spsp_if.sv */
// encoder terminal groups and mode line between host and drive
// second group is driven by the motor encoder, outside both ends
`timescale 1ns/100ps
`default_nettype none
interface spsp_if;
  logic first_group_phase_a;
  logic first_group_phase_b;
  logic first_group_index;
  logic second_group_phase_a;
  logic second_group_phase_b;
  logic second_group_index;
  logic serial_pulse_mode_cmd;
  modport dev (
    input first_group_phase_a, first_group_phase_b, first_group_index,
    input second_group_phase_a, second_group_phase_b, second_group_index,
    input serial_pulse_mode_cmd
  );
  modport host (
    output first_group_phase_a, first_group_phase_b, first_group_index,
    output serial_pulse_mode_cmd
  );
endinterface : spsp_if
`default_nettype wire

/* hw/spsp_quad.sv */
// pulse decoder for one encoder terminal group
// assumes phase lines are synchronous to clk
`timescale 1ns/100ps
`default_nettype none
`include "spsp_defs.svh"
module spsp_quad
  import spsp_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // lines and format
  input  wire logic       pha,
  input  wire logic       phb,
  input  wire logic [1:0] fmt,
  // decoded steps
  output logic            inc,
  output logic            dec
);
  logic pha_q;
  logic phb_q;
  logic rise_a;
  logic rise_b;

  always_ff @(posedge clk) begin
    if (rst) begin
      pha_q <= 1'b0;
      phb_q <= 1'b0;
    end else begin
      pha_q <= pha;
      phb_q <= phb;
    end
  end

  assign rise_a = pha & ~pha_q;
  assign rise_b = phb & ~phb_q;

  // ------------------------------------------------
  // format decode
  // ------------------------------------------------
  always_comb begin
    inc = 1'b0;
    dec = 1'b0;
    case (fmt)
      `SPSP_FMT_SIGN: begin
        inc = rise_a & ~phb;
        dec = rise_a & phb;
      end
      `SPSP_FMT_FWREV: begin
        inc = rise_a & ~rise_b;
        dec = rise_b & ~rise_a;
      end
      default: begin
        inc = rise_a & phb;
        dec = rise_a & ~phb;
      end
    endcase
  end
endmodule : spsp_quad
`default_nettype wire

/* hw/spsp_dev.sv */
// drive end: terminal routing, stop target and pulse-train counters
// assumes software port strobes are single-cycle and synchronous
//
// Contract
// - with positioning and reception enabled, pulses set target
// - received count held in stop target registers
// - decode serial pulses per selected input format
// - shared terminal counts only while mode on
// - dedicated terminal counts regardless of mode
// - two groups of A, B, index; function each
// - positioning only: first serial, second feedback
// - train, encoder speed, positioning: second does both
// - control methods 6 and 15 disable positioning
// - host waits 100 ms after mode on
// - no serial pulses 100 ms around mode off
// - host stops serial pulses 100 ms before off
// - host restarts speed train within 100 ms
// - train count frozen during mode plus 100 ms
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "spsp_defs.svh"
module spsp_dev
  import spsp_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = `SPSP_IDLE_CYC
)(
  // clock and reset
  input  wire logic        CLOCK,
  input  wire logic        SYS_RST,
  // terminals
  spsp_if.dev              LINK,
  // software port
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  // results
  output logic      [31:0] STOP_TARGET,
  output logic      [31:0] SPEED_REF_COUNT,
  output logic      [31:0] FEEDBACK_COUNT,
  output logic             POSITIONING_OK
);
  logic [31:0] cfg_q;
  logic [15:0] stop_lo_q;
  logic [15:0] stop_hi_q;
  logic [31:0] train_q;
  logic [31:0] fbk_q;
  logic [31:0] rdata_q;
  logic        mode_m_q;
  logic        mode_q;
  logic [23:0] hold_q;
  logic        freeze;
  logic        pt_sel;
  logic        sc_sel;
  logic        pos_ok;
  logic        dedicated;
  spsp_func_t  x_func;
  spsp_func_t  y_func;
  logic [1:0]  pha;
  logic [1:0]  phb;
  logic [1:0]  fmt [2];
  logic [1:0]  inc;
  logic [1:0]  dec;
  logic        ser_cnt;
  logic [31:0] stop_d;

  // ------------------------------------------------
  // mode synchroniser
  // ------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      mode_m_q  <= 1'b0;
      mode_q    <= 1'b0;
    end else begin
      mode_m_q  <= LINK.serial_pulse_mode_cmd;
      mode_q    <= mode_m_q;
    end
  end

  // ------------------------------------------------
  // terminal routing
  // ------------------------------------------------
  assign pt_sel = cfg_q[`SPSP_CFG_SRC] == `SPSP_SRC_TRAIN;
  assign sc_sel = (cfg_q[`SPSP_CFG_CM] == `SPSP_CM_PG_A) |
                  (cfg_q[`SPSP_CFG_CM] == `SPSP_CM_PG_B);
  assign pos_ok = cfg_q[`SPSP_CFG_SRA] &
                  (cfg_q[`SPSP_CFG_CM] != `SPSP_CM_NOPOS_A) &
                  (cfg_q[`SPSP_CFG_CM] != `SPSP_CM_NOPOS_B);
  assign dedicated = pos_ok & ~pt_sel & ~sc_sel;

  always_comb begin
    x_func = FN_MONITOR;
    y_func = FN_MONITOR;
    case ({pt_sel, sc_sel, pos_ok})
      3'h1: begin
        x_func = FN_SERIAL;
        y_func = FN_POSFBK;
      end
      3'h2: y_func = FN_SPEEDFBK;
      3'h3: begin
        x_func = mode_q ? FN_SERIAL : FN_POSFBK;
        y_func = FN_SPEEDFBK;
      end
      3'h4: x_func = FN_TRAIN;
      3'h5: begin
        x_func = mode_q ? FN_SERIAL : FN_TRAIN;
        y_func = FN_POSFBK;
      end
      3'h6: begin
        x_func = FN_TRAIN;
        y_func = FN_SPEEDFBK;
      end
      3'h7: begin
        x_func = mode_q ? FN_SERIAL : FN_TRAIN;
        y_func = FN_SPDPOS;
      end
      default: begin
        x_func = FN_MONITOR;
        y_func = FN_MONITOR;
      end
    endcase
  end

  // ------------------------------------------------
  // group decoders
  // ------------------------------------------------
  assign pha = {LINK.second_group_phase_a, LINK.first_group_phase_a};
  assign phb = {LINK.second_group_phase_b, LINK.first_group_phase_b};
  assign fmt[0] = (x_func == FN_SERIAL) ? cfg_q[`SPSP_CFG_FMT]
                                        : `SPSP_FMT_QUAD;
  assign fmt[1] = `SPSP_FMT_QUAD;

  for (genvar g = 0; g < 2; g++) begin : g_grp
    spsp_quad u_dec (
      .clk (CLOCK),
      .rst (SYS_RST),
      .pha (pha[g]),
      .phb (phb[g]),
      .fmt (fmt[g]),
      .inc (inc[g]),
      .dec (dec[g])
    );
  end

  // ------------------------------------------------
  // stop target count
  // ------------------------------------------------
  assign ser_cnt = cfg_q[`SPSP_CFG_SPEN] & (x_func == FN_SERIAL) &
                   (mode_q | dedicated);

  always_comb begin
    stop_d = {stop_hi_q, stop_lo_q};
    if (ser_cnt & inc[0]) begin
      stop_d = stop_d + 32'h1;
    end else if (ser_cnt & dec[0]) begin
      stop_d = stop_d - 32'h1;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      stop_lo_q <= 16'h0;
      stop_hi_q <= 16'h0;
    end else begin
      stop_lo_q <= stop_d[15:0];
      stop_hi_q <= stop_d[31:16];
      if (WR && ADDR == `SPSP_A_STOP_LO) begin
        stop_lo_q <= WDATA[15:0];
      end
      if (WR && ADDR == `SPSP_A_STOP_HI) begin
        stop_hi_q <= WDATA[15:0];
      end
    end
  end

  // ------------------------------------------------
  // speed reference hold
  // ------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      hold_q <= 24'h0;
    end else if (mode_q) begin
      hold_q <= HOLD_CYCLES[23:0];
    end else if (hold_q != 24'h0) begin
      hold_q <= hold_q - 24'h1;
    end
  end

  assign freeze = mode_q | (hold_q != 24'h0);

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      train_q <= 32'h0;
    end else if (x_func == FN_TRAIN && !freeze) begin
      if (inc[0]) begin
        train_q <= train_q + 32'h1;
      end else if (dec[0]) begin
        train_q <= train_q - 32'h1;
      end
    end
  end

  // ------------------------------------------------
  // feedback count
  // ------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      fbk_q <= 32'h0;
    end else if (y_func == FN_POSFBK || y_func == FN_SPDPOS) begin
      if (inc[1]) begin
        fbk_q <= fbk_q + 32'h1;
      end else if (dec[1]) begin
        fbk_q <= fbk_q - 32'h1;
      end
    end else if (x_func == FN_POSFBK) begin
      if (inc[0]) begin
        fbk_q <= fbk_q + 32'h1;
      end else if (dec[0]) begin
        fbk_q <= fbk_q - 32'h1;
      end
    end
  end

  // ------------------------------------------------
  // software registers
  // ------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      cfg_q <= `SPSP_CFG_RST;
    end else if (WR && ADDR == `SPSP_A_CFG) begin
      cfg_q <= {12'h0, WDATA[19:0]};
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      rdata_q <= 32'h0;
    end else if (RD) begin
      case (ADDR)
        `SPSP_A_CFG:     rdata_q <= cfg_q;
        `SPSP_A_STOP_LO: rdata_q <= {16'h0, stop_lo_q};
        `SPSP_A_STOP_HI: rdata_q <= {16'h0, stop_hi_q};
        `SPSP_A_STATUS:  rdata_q <= {20'h0, LINK.second_group_index,
                                     LINK.first_group_index, freeze,
                                     dedicated, pos_ok, mode_q,
                                     y_func, x_func};
        `SPSP_A_TRAIN:   rdata_q <= train_q;
        `SPSP_A_FBK:     rdata_q <= fbk_q;
        default:         rdata_q <= 32'h0;
      endcase
    end else begin
      rdata_q <= 32'h0;
    end
  end

  assign RDATA           = rdata_q;
  assign STOP_TARGET     = {stop_hi_q, stop_lo_q};
  assign SPEED_REF_COUNT = train_q;
  assign FEEDBACK_COUNT  = fbk_q;
  assign POSITIONING_OK  = pos_ok;
endmodule : spsp_dev
`default_nettype wire

/* hw/spsp_host.sv */
// host end: mode sequencing and pulse generation on first group
// assumes the user side holds requests as levels or single pulses
`timescale 1ns/100ps
`default_nettype none
`include "spsp_defs.svh"
module spsp_host
  import spsp_pkg::*;
#(
  parameter int unsigned IDLE_CYCLES = `SPSP_IDLE_CYC
)(
  // clock and reset
  input  wire logic        CLOCK,
  input  wire logic        SYS_RST,
  // terminals
  spsp_if.host             LINK,
  // user requests
  input  wire logic        MODE_REQ,
  input  wire logic        SPEED_EN,
  input  wire logic        SEND,
  input  wire logic [15:0] COUNT,
  input  wire logic        DIR_REV,
  input  wire logic [1:0]  FORMAT,
  // status
  output logic             READY,
  output logic             MODE_ON
);
  spsp_hstate_t st_q;
  logic [23:0]  tmr_q;
  logic         tmr_done;
  logic [7:0]   div_q;
  logic         tick;
  logic [1:0]   ph_q;
  logic [15:0]  left_q;
  logic         run;
  logic         a_q;
  logic         b_q;

  // ------------------------------------------------
  // pulse rate divider
  // ------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (SYS_RST || div_q == `SPSP_TICK_DIV - 8'h1) begin
      div_q <= 8'h0;
    end else begin
      div_q <= div_q + 8'h1;
    end
  end
  assign tick = div_q == `SPSP_TICK_DIV - 8'h1;

  // ------------------------------------------------
  // mode sequencer
  // ------------------------------------------------
  assign tmr_done = tmr_q >= IDLE_CYCLES[23:0];

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      st_q   <= H_OFF;
      tmr_q  <= 24'h0;
      left_q <= 16'h0;
    end else begin
      if (!tmr_done) begin
        tmr_q <= tmr_q + 24'h1;
      end
      case (st_q)
        H_OFF: if (MODE_REQ && ph_q == 2'h0 && !a_q) begin
          st_q  <= H_ON_WAIT;
          tmr_q <= 24'h0;
        end
        H_ON_WAIT: if (tmr_done) begin
          st_q <= H_READY;
        end
        H_READY: if (SEND && COUNT != 16'h0) begin
          st_q   <= H_SEND;
          left_q <= COUNT;
        end else if (!MODE_REQ && tmr_done) begin
          st_q  <= SPEED_EN ? H_OFF : H_POST_OFF;
          tmr_q <= 24'h0;
        end
        H_SEND: if (tick && ph_q == 2'h3) begin
          left_q <= left_q - 16'h1;
          if (left_q == 16'h1) begin
            st_q  <= H_READY;
            tmr_q <= 24'h0;
          end
        end
        H_POST_OFF: if (tmr_done || SPEED_EN) begin
          st_q <= H_OFF;
        end
        default: st_q <= H_OFF;
      endcase
    end
  end

  // ------------------------------------------------
  // pulse generator
  // ------------------------------------------------
  assign run = (st_q == H_SEND) || (st_q == H_OFF && SPEED_EN);

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      ph_q <= 2'h0;
    end else if (tick && (run || ph_q != 2'h0)) begin
      ph_q <= ph_q + 2'h1;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
    end else begin
      case (FORMAT)
        `SPSP_FMT_SIGN: begin
          a_q <= ph_q[1];
          b_q <= DIR_REV;
        end
        `SPSP_FMT_FWREV: begin
          a_q <= ph_q[1] & ~DIR_REV;
          b_q <= ph_q[1] & DIR_REV;
        end
        default: begin
          a_q <= ph_q[1];
          b_q <= (ph_q[1] ^ ph_q[0]) ^ DIR_REV;
        end
      endcase
    end
  end

  assign LINK.first_group_phase_a   = a_q;
  assign LINK.first_group_phase_b   = b_q;
  assign LINK.first_group_index     = 1'b0;
  assign LINK.serial_pulse_mode_cmd = (st_q != H_OFF) && (st_q != H_POST_OFF);
  assign READY   = st_q == H_READY;
  assign MODE_ON = LINK.serial_pulse_mode_cmd;
endmodule : spsp_host
`default_nettype wire

/* verification/spsp_assertions.sv */
// checks on the link wires between the host and drive ends
// assumes one clock and a synchronous active high reset
`timescale 1ns/100ps
`default_nettype none
module spsp_assertions #(
  parameter int unsigned IDLE_CYCLES = 200
)(
  // clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // first group and mode line
  input wire logic first_group_phase_a,
  input wire logic first_group_phase_b,
  input wire logic first_group_index,
  input wire logic serial_pulse_mode_cmd
);
  localparam int unsigned QUIET_MIN = IDLE_CYCLES - 2;
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SYS_RST);
  logic [19:0] on_q;
  logic [19:0] quiet_q;
  // ----------------------------------------
  // cycles in mode, cycles since a line edge
  // ----------------------------------------
  always_ff @(posedge CLOCK) begin
    if (SYS_RST || !serial_pulse_mode_cmd) on_q <= '0;
    else if (!(&on_q)) on_q <= on_q + 20'h1;
  end
  always_ff @(posedge CLOCK) begin
    if (SYS_RST || $changed(first_group_phase_a) || $changed(first_group_phase_b)) quiet_q <= '0;
    else if (!(&quiet_q)) quiet_q <= quiet_q + 20'h1;
  end
  sequence s_edge;
    $rose(first_group_phase_a) || $rose(first_group_phase_b);
  endsequence
  sequence s_still;
    $stable(first_group_phase_a) && $stable(first_group_phase_b);
  endsequence
  AST_WAIT_AFTER_ON: assert property (s_edge ##0 serial_pulse_mode_cmd |-> on_q >= IDLE_CYCLES)
    else $error("serial pulse too soon after mode on");
  AST_STILL_AT_ON: assert property ($rose(serial_pulse_mode_cmd) |-> s_still [*8])
    else $error("lines moved as mode turned on");
  AST_QUIET_BEFORE_OFF: assert property ($fell(serial_pulse_mode_cmd) |-> quiet_q >= QUIET_MIN)
    else $error("mode dropped too soon after a pulse");
  AST_HIGH_WIDTH: assert property ($rose(first_group_phase_a) |-> first_group_phase_a [*8])
    else $error("phase a high too short");
  AST_LOW_WIDTH: assert property ($fell(first_group_phase_a) |-> !first_group_phase_a [*8])
    else $error("phase a low too short");
  AST_B_STEADY: assert property ($rose(first_group_phase_a) |-> $stable(first_group_phase_b))
    else $error("phase b moved with phase a");
  AST_NO_TWIN: assert property (!($rose(first_group_phase_a) && $rose(first_group_phase_b)))
    else $error("both phases rose together");
  AST_INDEX_IDLE: assert property (!first_group_index)
    else $error("first group index driven");
endmodule : spsp_assertions
`default_nettype wire

/* verification/serial_pulse_stop_position_input_bench.sv */
// bench: host and drive ends joined by the link, random traffic with corner cases
// assumes package, interface, design and checker sources compiled before it
`timescale 1ns/100ps
`default_nettype none
`include "spsp_defs.svh"
module serial_pulse_stop_position_input_bench
  import spsp_pkg::*;
;
  localparam int unsigned IDLE  = 200;
  localparam int          LIMIT = 40000;
  localparam logic [7:0]  CMS [5] = '{8'h00, `SPSP_CM_PG_A, `SPSP_CM_PG_B, `SPSP_CM_NOPOS_A, `SPSP_CM_NOPOS_B};
  logic        CLOCK = 1'b0;
  logic        SYS_RST = 1'b1;
  logic [7:0]  ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic        WR = 1'b0;
  logic        RD = 1'b0;
  logic        MODE_REQ = 1'b0;
  logic        SPEED_EN = 1'b0;
  logic        SEND = 1'b0;
  logic [15:0] COUNT = 16'h0;
  logic        DIR_REV = 1'b0;
  logic [1:0]  FORMAT = 2'h0;
  logic [31:0] RDATA;
  logic [31:0] STOP_TARGET;
  logic [31:0] SPEED_REF_COUNT;
  logic [31:0] FEEDBACK_COUNT;
  logic        POSITIONING_OK;
  logic        READY;
  logic        MODE_ON;
  logic [31:0] seed;
  logic [31:0] d;
  logic [31:0] tr;
  logic [31:0] s0;
  int          n_errors = 0;
  int          check_count = 0;
  int          cyc = 0;
  spsp_if link ();
  spsp_dev #(.HOLD_CYCLES(IDLE)) u_spsp_dev (
    .CLOCK(CLOCK), .SYS_RST(SYS_RST), .LINK(link), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .STOP_TARGET(STOP_TARGET), .SPEED_REF_COUNT(SPEED_REF_COUNT),
    .FEEDBACK_COUNT(FEEDBACK_COUNT), .POSITIONING_OK(POSITIONING_OK));
  spsp_host #(.IDLE_CYCLES(IDLE)) u_spsp_host (
    .CLOCK(CLOCK), .SYS_RST(SYS_RST), .LINK(link), .MODE_REQ(MODE_REQ), .SPEED_EN(SPEED_EN),
    .SEND(SEND), .COUNT(COUNT), .DIR_REV(DIR_REV), .FORMAT(FORMAT), .READY(READY), .MODE_ON(MODE_ON));
  spsp_assertions #(.IDLE_CYCLES(IDLE)) u_spsp_assertions (
    .CLOCK(CLOCK), .SYS_RST(SYS_RST), .first_group_phase_a(link.first_group_phase_a),
    .first_group_phase_b(link.first_group_phase_b), .first_group_index(link.first_group_index),
    .serial_pulse_mode_cmd(link.serial_pulse_mode_cmd));
  // ----------------------------------------
  // clock, watchdog, helpers
  // ----------------------------------------
  always #5 CLOCK = ~CLOCK;
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_errors++;
      conclude();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  function automatic logic [31:0] cfg(input logic t, pos, en, input logic [1:0] f, input logic [7:0] cm);
    return {12'h0, en, pos, f, cm, t ? `SPSP_SRC_TRAIN : 8'h00};
  endfunction : cfg
  function automatic logic [5:0] exp_route(input logic t, pg, pos, m);
    spsp_func_t x;
    spsp_func_t y;
    x = t ? ((pos && m) ? FN_SERIAL : FN_TRAIN) : pg ? (pos ? (m ? FN_SERIAL : FN_POSFBK) : FN_MONITOR)
          : (pos ? FN_SERIAL : FN_MONITOR);
    y = pg ? ((pos && t) ? FN_SPDPOS : FN_SPEEDFBK) : (pos ? FN_POSFBK : FN_MONITOR);
    return {y, x};
  endfunction : exp_route
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge CLOCK);
    WR    <= 1'b1;
    ADDR  <= a;
    WDATA <= v;
    @(posedge CLOCK);
    WR <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge CLOCK);
    RD   <= 1'b1;
    ADDR <= a;
    @(posedge CLOCK);
    RD <= 1'b0;
    #1;
    v = RDATA;
  endtask : rd
  task automatic waitfor(input logic m, input logic lvl);
    for (int i = 0; i < 3000; i++) begin
      @(posedge CLOCK);
      #1;
      if ((m ? MODE_ON : READY) === lvl) break;
    end
    chk("handshake", {31'h0, m ? MODE_ON : READY}, {31'h0, lvl});
  endtask : waitfor
  task automatic set_mode(input logic on);
    @(posedge CLOCK);
    MODE_REQ <= on;
    waitfor(1'b1, on);
    if (on) waitfor(1'b0, 1'b1);
  endtask : set_mode
  task automatic send(input logic [15:0] n);
    @(posedge CLOCK);
    SEND  <= 1'b1;
    COUNT <= n;
    @(posedge CLOCK);
    SEND <= 1'b0;
    waitfor(1'b0, 1'b1);
  endtask : send
  task automatic route(input logic m);
    logic [31:0] st;
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      wr(`SPSP_A_CFG, cfg(i[2], i[0], 1'b1, seed[1:0], i[1] ? (seed[0] ? 8'h03 : 8'h04) : 8'h00));
      rd(`SPSP_A_STATUS, st);
      chk("route", {26'h0, st[5:0]}, {26'h0, exp_route(i[2], i[1], i[0], m)});
      chk("mode seen", {31'h0, st[6]}, {31'h0, m});
      chk("dedicated", {31'h0, st[8]}, {31'h0, i[0] & ~i[1] & ~i[2]});
    end
    $display("test route done");
  endtask : route
  task automatic pulses(input logic [31:0] c, input logic live);
    logic [31:0] init;
    logic [31:0] exp;
    logic [31:0] v;
    logic [15:0] n;
    seed = xs(seed);
    init = {16'h0001, seed[15:0]};
    n = {14'h0, seed[17:16]} + 16'h1;
    FORMAT  <= c[17:16];
    DIR_REV <= seed[18];
    wr(`SPSP_A_CFG, c);
    wr(`SPSP_A_STOP_LO, {seed[31:16], init[15:0]});
    wr(`SPSP_A_STOP_HI, 32'h1);
    send(n);
    exp = live ? (seed[18] ? init - n : init + n) : init;
    chk("stop target", STOP_TARGET, exp);
    rd(`SPSP_A_STOP_LO, v);
    chk("stop low", v, {16'h0, exp[15:0]});
  endtask : pulses
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    link.second_group_phase_a = 1'b0;
    link.second_group_phase_b = 1'b0;
    link.second_group_index = 1'b0;
    seed = 32'h0000_74fc;
    repeat (2) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    for (int a = 0; a < 7; a++) begin
      rd(8'(a * 4), d);
      chk("reset value", d, 32'h0);
    end
    chk("positioning ok", {31'h0, POSITIONING_OK}, 32'h0);
    seed = xs(seed);
    wr(8'h18, seed);
    rd(8'h18, d);
    chk("unmapped", d, 32'h0);
    wr(`SPSP_A_CFG, 32'hffff_ffff);
    rd(`SPSP_A_CFG, d);
    chk("cfg mask", d, 32'h000f_ffff);
    wr(`SPSP_A_STOP_HI, 32'hffff_ffff);
    rd(`SPSP_A_STOP_HI, d);
    chk("stop hi mask", d, 32'h0000_ffff);
    for (int i = 0; i < 5; i++) begin
      wr(`SPSP_A_CFG, cfg(1'b0, 1'b1, 1'b1, 2'h0, CMS[i]));
      chk("positioning ok", {31'h0, POSITIONING_OK}, {31'h0, i < 3});
    end
    $display("test registers done");
    route(1'b0);
    wr(`SPSP_A_CFG, cfg(1'b1, 1'b1, 1'b1, 2'h0, 8'h00));
    SPEED_EN <= 1'b1;
    repeat (1500) @(posedge CLOCK);
    #1;
    chk("train counted", {31'h0, SPEED_REF_COUNT != 0}, 32'h1);
    SPEED_EN <= 1'b0;
    set_mode(1'b1);
    tr = SPEED_REF_COUNT;
    route(1'b1);
    for (int f = 0; f < 4; f++) pulses(cfg(1'b0, 1'b1, 1'b1, 2'(f), 8'h00), 1'b1);
    pulses(cfg(1'b0, 1'b1, 1'b0, 2'h0, 8'h00), 1'b0);
    pulses(cfg(1'b1, 1'b1, 1'b1, seed[1:0], {6'h0, seed[2], seed[2]}), 1'b1);
    chk("train frozen", SPEED_REF_COUNT, tr);
    $display("test counting done");
    wr(`SPSP_A_CFG, cfg(1'b0, 1'b1, 1'b1, 2'h2, 8'h00));
    s0 = FEEDBACK_COUNT;
    for (int k = 1; k <= 16; k++) begin
      repeat (3) @(posedge CLOCK);
      {link.second_group_phase_a, link.second_group_phase_b} <= {k[1], k[1] ^ k[0]};
    end
    repeat (4) @(posedge CLOCK);
    #1;
    chk("feedback moved", FEEDBACK_COUNT, s0 + 32'h4);
    $display("test feedback done");
    wr(`SPSP_A_CFG, cfg(1'b1, 1'b1, 1'b1, 2'h0, 8'h00));
    SPEED_EN <= 1'b1;
    set_mode(1'b0);
    s0 = STOP_TARGET;
    repeat (IDLE / 2) @(posedge CLOCK);
    #1;
    chk("train held", SPEED_REF_COUNT, tr);
    repeat (1500) @(posedge CLOCK);
    #1;
    chk("train resumed", {31'h0, SPEED_REF_COUNT != tr}, 32'h1);
    chk("target kept", STOP_TARGET, s0);
    $display("test mode off done");
    conclude();
  end
endmodule : serial_pulse_stop_position_input_bench
`default_nettype wire
